// *** sim/bsc_sock_model.sv ***
// Behavioural model of the two card sockets and of the lower register half.
module bsc_sock_model (
  input  wire logic   clk_sys,
  output logic [15:0] lower_rdata,
  output logic [1:0]  power_write,
  output logic [1:0]  card_present_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // The lower half belongs to other logic; a fixed image stands in for it.
  localparam logic [15:0] LOWER_IMAGE = 16'h9060;
  assign lower_rdata = LOWER_IMAGE;

  // No card seated and no power write pending at start.
  initial begin
    power_write      = 2'h0;
    card_present_pin = 2'h0;
  end

  // A socket power write lasts exactly one clock, launched off the falling edge.
  task automatic power_pulse(input int s);
    @(negedge clk_sys);
    power_write[s] = 1'b1;
    @(negedge clk_sys);
    power_write[s] = 1'b0;
  endtask

  // Seating a card is asynchronous to the clock, so it lands between edges.
  task automatic seat(input int s, input logic v);
    #3;
    card_present_pin[s] = v;
  endtask
endmodule // bsc_sock_model

// *** sim/tb_bsc_sysctl.sv ***
// Self-checking testbench for the upper system control half.
module tb_bsc_sysctl;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_sys;
  logic                  srst;
  bsc_pkg::bsc_cfg_req_t cfg_req;
  logic [15:0]           lower_rdata;
  logic [31:0]           cfg_rdata;
  logic                  cfg_rvalid;
  logic [1:0]            pci_int_req;
  logic [3:0]            serial_irq_stream;
  logic [1:0]            power_write;
  logic [1:0]            card_present_pin;
  logic [1:0]            cb_spare_pin_o;
  logic [1:0]            cb_spare_pin_oe;
  logic [1:0]            supply_guard_disable;
  logic [1:0]            video_addr_float;
  logic                  irq2_req;
  logic [1:0]            card_status_change_irq;
  logic                  switch_clock_source;
  logic                  switch_clk_o;
  logic                  switch_clk_oe;
  int                    err_total;
  int                    cmp_count;
  int                    n;
  logic [31:0]           d;
  logic [3:0]            s_exp;
  logic                  last;

  bsc_sysctl u_dut (.clk_sys(clk_sys), .srst(srst), .cfg_req(cfg_req), .lower_rdata(lower_rdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .pci_int_req(pci_int_req),
    .serial_irq_stream(serial_irq_stream), .power_write(power_write), .card_present_pin(card_present_pin),
    .cb_spare_pin_o(cb_spare_pin_o), .cb_spare_pin_oe(cb_spare_pin_oe),
    .supply_guard_disable(supply_guard_disable), .video_addr_float(video_addr_float), .irq2_req(irq2_req),
    .card_status_change_irq(card_status_change_irq), .switch_clock_source(switch_clock_source),
    .switch_clk_o(switch_clk_o), .switch_clk_oe(switch_clk_oe));

  bsc_sock_model u_sock (.clk_sys(clk_sys), .lower_rdata(lower_rdata), .power_write(power_write),
    .card_present_pin(card_present_pin));

  // Free-running 100 MHz clock.
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // Every comparison is counted; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // A write is a single-cycle request launched off the falling edge.
  task automatic cfg_wr(input logic f, input logic [7:0] off, input logic [3:0] bes, input logic [31:0] wd);
    @(negedge clk_sys);
    cfg_req = '{1'b0, 1'b1, f, off, bes, wd};
    @(negedge clk_sys);
    cfg_req = '0;
  endtask

  // The answer stands for one cycle only, so it is taken at the next falling edge.
  task automatic cfg_rd(input logic f, input logic [7:0] off, output logic [31:0] rd);
    @(negedge clk_sys);
    cfg_req = '{1'b1, 1'b0, f, off, 4'hf, 32'h0};
    @(negedge clk_sys);
    cfg_req = '0;
    chk({31'h0, cfg_rvalid}, 32'h1, "read valid");
    rd = cfg_rdata;
  endtask

  // Slot stream the rules call for: the tie folds the second request onto the first.
  function automatic logic [3:0] stream_of(input int step, input logic tie, input logic [1:0] req);
    logic [3:0] s;
    s = 4'h0;
    s[step] = req[0] | (tie & req[1]);
    s[(step + 1) % 4] = s[(step + 1) % 4] | (~tie & req[1]);
    return s;
  endfunction

  // Single place where the run ends.
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog so that a hang still reaches the verdict.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("unexpected at %0t: run did not complete", $time);
    end_sim();
  end

  // Main sequence.
  initial begin
    err_total = 0;
    cmp_count = 0;
    srst = 1'b1;
    cfg_req = '0;
    pci_int_req = 2'h0;
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    cfg_rd(1'b0, 8'h80, d);
    chk(d, 32'h0040_9060, "reset image f0");
    cfg_rd(1'b1, 8'h80, d);
    chk(d, 32'h0040_9060, "reset image f1");
    // All ones through function 0: reserved bits stay zero, the flag cannot be set by software.
    cfg_wr(1'b0, 8'h80, 4'hc, 32'hffff_ffff);
    cfg_rd(1'b0, 8'h80, d);
    chk(d, 32'hed70_9060, "all ones f0");
    cfg_rd(1'b1, 8'h80, d);
    chk(d, 32'hed40_9060, "globals seen in f1");
    chk({30'h0, supply_guard_disable}, 32'h1, "guard disable");
    chk({30'h0, video_addr_float}, 32'h1, "address float");
    chk({30'h0, switch_clock_source, switch_clk_oe}, 32'h3, "clock source driven");
    // The generated clock must keep a fixed half period.
    last = switch_clk_o;
    n = 0;
    while (switch_clk_o === last && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20) begin
      err_total++;
      $display("unexpected at %0t: switch clock never toggled", $time);
    end
    last = switch_clk_o;
    n = 0;
    while (switch_clk_o === last && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, {28'h0, bsc_pkg::SWCLK_HALF_CYC}, "switch clock half period");
    // Back to an external clock, as the system needs while suspended.
    cfg_wr(1'b0, 8'h80, 4'hc, 32'h0);
    chk({30'h0, switch_clock_source, switch_clk_oe}, 32'h0, "clock source input");
    cfg_wr(1'b0, 8'h84, 4'hf, 32'hffff_ffff);
    cfg_rd(1'b0, 8'h80, d);
    chk(d, 32'h0000_9060, "other offset ignored");
    cfg_rd(1'b0, 8'h84, d);
    chk(d, 32'h0, "other offset reads zero");
    // Every step value with and without the tie, against every request pattern.
    for (int st = 0; st < 4; st++) begin
      for (int t = 0; t < 2; t++) begin
        // The stream pin is assumed already configured before the tie is set.
        cfg_wr(1'b0, 8'h80, 4'h8, {st[1:0], t[0], 29'h0});
        for (int r = 0; r < 4; r++) begin
          pci_int_req = r[1:0];
          @(negedge clk_sys);
          s_exp = stream_of(st, t[0], r[1:0]);
          chk({28'h0, serial_irq_stream}, {28'h0, s_exp}, "slot stream");
        end
      end
    end
    pci_int_req = 2'h0;
    // Power write flag, routed to IRQ2, then cleared by writing one.
    u_sock.power_pulse(0);
    cfg_rd(1'b0, 8'h80, d);
    chk(d & 32'h0200_0000, 32'h0, "flag ignores pulse while off");
    cfg_wr(1'b0, 8'h80, 4'h8, 32'h0100_0000);
    u_sock.power_pulse(0);
    chk({31'h0, irq2_req}, 32'h1, "irq2 raised");
    chk({30'h0, card_status_change_irq}, 32'h0, "no status irq");
    cfg_rd(1'b0, 8'h80, d);
    chk(d & 32'h0200_0000, 32'h0200_0000, "flag set f0");
    cfg_rd(1'b1, 8'h80, d);
    chk(d & 32'h0200_0000, 32'h0, "flag clear f1");
    cfg_wr(1'b0, 8'h80, 4'h8, 32'h0300_0000);
    chk({31'h0, irq2_req}, 32'h0, "irq2 dropped");
    cfg_rd(1'b0, 8'h80, d);
    chk(d & 32'h0200_0000, 32'h0, "flag cleared");
    // Routed to the status-change interrupt, then held only while enabled.
    cfg_wr(1'b0, 8'h80, 4'h8, 32'h0500_0000);
    u_sock.power_pulse(1);
    chk({29'h0, irq2_req, card_status_change_irq}, 32'h2, "status irq socket 1");
    cfg_wr(1'b0, 8'h80, 4'h8, 32'h0400_0000);
    chk({29'h0, irq2_req, card_status_change_irq}, 32'h0, "irq off with enable");
    cfg_rd(1'b1, 8'h80, d);
    chk(d & 32'h0200_0000, 32'h0200_0000, "flag kept");
    // Spare terminals: socket 0 lost its drive bit above, so it is set again first.
    cfg_wr(1'b0, 8'h80, 4'h4, 32'h0040_0000);
    u_sock.seat(0, 1'b1);
    u_sock.seat(1, 1'b1);
    repeat (4) @(negedge clk_sys);
    chk({28'h0, cb_spare_pin_oe, cb_spare_pin_o}, 32'hc, "spare drive both");
    cfg_wr(1'b0, 8'h80, 4'h4, 32'h0);
    chk({28'h0, cb_spare_pin_oe, cb_spare_pin_o}, 32'h8, "spare float socket 0");
    end_sim();
  end
endmodule // tb_bsc_sysctl

// *** src/bsc_pkg.sv ***
// Constants, field positions and carrier types for the upper system control half.
package bsc_pkg;

  // Register placement and reset image.
  localparam logic [7:0]  SYSCTL_OFFSET = 8'h80;
  localparam logic [31:0] SYSCTL_RESET  = 32'h0040_9060;

  // Field positions in the 32-bit word.
  localparam int STEP_LSB  = 30;
  localparam int TIE_BIT   = 29;
  localparam int SRC_BIT   = 27;
  localparam int ROUTE_BIT = 26;
  localparam int FLAG_BIT  = 25;
  localparam int EN_BIT    = 24;
  localparam int SPARE_BIT = 22;
  localparam int GUARD_BIT = 21;
  localparam int FLOAT_BIT = 20;

  // Byte lanes that carry the upper half.
  localparam int LANE_HI  = 3;
  localparam int LANE_MID = 2;

  // Counts and sizes.
  localparam int NUM_SOCKETS = 2;
  localparam int NUM_SLOTS   = 4;
  // Half period of the generated power-switch clock, in cycles of clk_sys.
  localparam logic [3:0] SWCLK_HALF_CYC = 4'h4;

  // One configuration-space access, presented for a single clk_sys cycle.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        func;
    logic [7:0]  offset;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bsc_cfg_req_t;

  // Per-socket control bits as stored.
  typedef struct packed {
    logic flag;
    logic spare_drive;
    logic guard_disable;
    logic addr_float;
  } bsc_sock_bits_t;

endpackage : bsc_pkg

// *** src/bsc_socket.sv ***
// Per-socket control bits, power-write flag and spare terminal drive.
module bsc_socket (
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic                    wr_hit,
  input  wire logic [1:0]              wr_lane,
  input  wire logic [15:0]             wdata_hi,
  input  wire logic                    power_write,
  input  wire logic                    irq_enable,
  input  wire logic                    card_present_pin,
  output bsc_pkg::bsc_sock_bits_t      bits,
  output logic                         spare_pin_o,
  output logic                         spare_pin_oe
);

  logic [1:0] present_sync_reg;
  logic       flag_clear;
  logic       flag_reg;
  logic       spare_drive_reg;
  logic       guard_disable_reg;
  logic       addr_float_reg;

  // Card presence comes from a pin; only the second stage is used.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      present_sync_reg <= 2'h0;
    end else begin
      present_sync_reg <= {present_sync_reg[0], card_present_pin};
    end
  end

  assign flag_clear = wr_hit && wr_lane[1] && wdata_hi[bsc_pkg::FLAG_BIT - 16];

  // The flag is set on a power write while enabled; a set in the clear cycle wins.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_reg <= bsc_pkg::SYSCTL_RESET[bsc_pkg::FLAG_BIT];
    end else if (power_write && irq_enable) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  // Plain read/write bits in the second byte lane.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      spare_drive_reg   <= bsc_pkg::SYSCTL_RESET[bsc_pkg::SPARE_BIT];
      guard_disable_reg <= bsc_pkg::SYSCTL_RESET[bsc_pkg::GUARD_BIT];
      addr_float_reg    <= bsc_pkg::SYSCTL_RESET[bsc_pkg::FLOAT_BIT];
    end else if (wr_hit && wr_lane[0]) begin
      spare_drive_reg   <= wdata_hi[bsc_pkg::SPARE_BIT - 16];
      guard_disable_reg <= wdata_hi[bsc_pkg::GUARD_BIT - 16];
      addr_float_reg    <= wdata_hi[bsc_pkg::FLOAT_BIT - 16];
    end
  end

  // Each bit has its own register so that no two processes share one variable.
  assign bits = '{flag_reg, spare_drive_reg, guard_disable_reg, addr_float_reg};

  // Spare terminals are pulled low only with a card seated; otherwise released.
  assign spare_pin_o  = 1'b0;
  assign spare_pin_oe = spare_drive_reg && present_sync_reg[1];

  property p_flag_set;
    @(posedge clk_sys) disable iff (srst)
    power_write && irq_enable |=> bits.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set after enabled power write");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (srst)
    flag_clear && !(power_write && irq_enable) |=> !bits.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write of one");

  property p_flag_hold;
    @(posedge clk_sys) disable iff (srst)
    !bits.flag && !(power_write && irq_enable) |=> !bits.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag set without cause");

  property p_spare_drive;
    @(posedge clk_sys) disable iff (srst)
    bits.spare_drive && !$past(srst) && !$past(srst, 2)
      && $past(card_present_pin, 2) && $past(card_present_pin, 3)
      |-> spare_pin_oe && !spare_pin_o;
  endproperty
  a_spare_drive: assert property (p_spare_drive) else $error("spare terminals not driven low");

  property p_spare_float;
    @(posedge clk_sys) disable iff (srst)
    !bits.spare_drive |-> !spare_pin_oe;
  endproperty
  a_spare_float: assert property (p_spare_float) else $error("spare terminals driven while off");

  c_flag_cycle: cover property (@(posedge clk_sys) disable iff (srst) bits.flag ##[1:20] !bits.flag);

endmodule : bsc_socket

// *** src/bsc_sysctl.sv ***
// Upper half of the bridge system control register and the logic it steers.
module bsc_sysctl (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire bsc_pkg::bsc_cfg_req_t cfg_req,
  input  wire logic [15:0]           lower_rdata,
  output logic [31:0]                cfg_rdata,
  output logic                       cfg_rvalid,
  input  wire logic [1:0]            pci_int_req,
  output logic [3:0]                 serial_irq_stream,
  input  wire logic [1:0]            power_write,
  input  wire logic [1:0]            card_present_pin,
  output logic [1:0]                 cb_spare_pin_o,
  output logic [1:0]                 cb_spare_pin_oe,
  output logic [1:0]                 supply_guard_disable,
  output logic [1:0]                 video_addr_float,
  output logic                       irq2_req,
  output logic [1:0]                 card_status_change_irq,
  output logic                       switch_clock_source,
  output logic                       switch_clk_o,
  output logic                       switch_clk_oe
);

  logic [1:0]                 irq_slot_step_reg;
  logic                       tie_pci_irqs_reg;
  logic                       switch_clock_source_reg;
  logic                       power_write_irq_route_reg;
  logic                       power_write_irq_enable_reg;
  logic                       wr_hit;
  logic [1:0]                 irq_level;
  logic [3:0]                 slots_next;
  logic [3:0]                 swclk_cnt_reg;
  logic                       swclk_reg;
  bsc_pkg::bsc_sock_bits_t    sock_bits [bsc_pkg::NUM_SOCKETS];

  // Builds the read image of the upper half for one function.
  function automatic logic [15:0] upper_image(input logic f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[bsc_pkg::STEP_LSB +: 2] = irq_slot_step_reg;
    w[bsc_pkg::TIE_BIT]       = tie_pci_irqs_reg;
    w[bsc_pkg::SRC_BIT]       = switch_clock_source_reg;
    w[bsc_pkg::ROUTE_BIT]     = power_write_irq_route_reg;
    w[bsc_pkg::FLAG_BIT]      = sock_bits[f].flag;
    w[bsc_pkg::EN_BIT]        = power_write_irq_enable_reg;
    w[bsc_pkg::SPARE_BIT]     = sock_bits[f].spare_drive;
    w[bsc_pkg::GUARD_BIT]     = sock_bits[f].guard_disable;
    w[bsc_pkg::FLOAT_BIT]     = sock_bits[f].addr_float;
    return w[31:16];
  endfunction

  assign wr_hit = cfg_req.wr && (cfg_req.offset == bsc_pkg::SYSCTL_OFFSET);

  // Global bits keep a single copy; either function reaches it, so the
  // firmware is trusted to use function zero only.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_slot_step_reg          <= bsc_pkg::SYSCTL_RESET[bsc_pkg::STEP_LSB +: 2];
      tie_pci_irqs_reg           <= bsc_pkg::SYSCTL_RESET[bsc_pkg::TIE_BIT];
      switch_clock_source_reg    <= bsc_pkg::SYSCTL_RESET[bsc_pkg::SRC_BIT];
      power_write_irq_route_reg  <= bsc_pkg::SYSCTL_RESET[bsc_pkg::ROUTE_BIT];
      power_write_irq_enable_reg <= bsc_pkg::SYSCTL_RESET[bsc_pkg::EN_BIT];
    end else if (wr_hit && cfg_req.be[bsc_pkg::LANE_HI]) begin
      irq_slot_step_reg          <= cfg_req.wdata[bsc_pkg::STEP_LSB +: 2];
      tie_pci_irqs_reg           <= cfg_req.wdata[bsc_pkg::TIE_BIT];
      switch_clock_source_reg    <= cfg_req.wdata[bsc_pkg::SRC_BIT];
      power_write_irq_route_reg  <= cfg_req.wdata[bsc_pkg::ROUTE_BIT];
      power_write_irq_enable_reg <= cfg_req.wdata[bsc_pkg::EN_BIT];
    end
  end

  // Per-socket bits live in one instance per function.
  for (genvar s = 0; s < bsc_pkg::NUM_SOCKETS; s++) begin : g_sock
    bsc_socket u_sock (
      .clk_sys          (clk_sys),
      .srst             (srst),
      .wr_hit           (wr_hit && (cfg_req.func == 1'(s))),
      .wr_lane          ({cfg_req.be[bsc_pkg::LANE_HI], cfg_req.be[bsc_pkg::LANE_MID]}),
      .wdata_hi         (cfg_req.wdata[31:16]),
      .power_write      (power_write[s]),
      .irq_enable       (power_write_irq_enable_reg),
      .card_present_pin (card_present_pin[s]),
      .bits             (sock_bits[s]),
      .spare_pin_o      (cb_spare_pin_o[s]),
      .spare_pin_oe     (cb_spare_pin_oe[s])
    );
    assign supply_guard_disable[s] = sock_bits[s].guard_disable;
    assign video_addr_float[s]     = sock_bits[s].addr_float;
    assign irq_level[s]            = sock_bits[s].flag && power_write_irq_enable_reg;
    assign card_status_change_irq[s] = irq_level[s] && power_write_irq_route_reg;
  end

  // The request stays up for as long as flag and enable stay up with the route bit clear.
  assign irq2_req = |irq_level && !power_write_irq_route_reg;

  // Read answer one cycle after the request; unmapped offsets read zero.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
      if (cfg_req.rd && cfg_req.offset == bsc_pkg::SYSCTL_OFFSET) begin
        cfg_rdata <= {upper_image(cfg_req.func), lower_rdata};
      end else begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  // Tie folds both requests onto the first; the step then rotates the pair.
  always_comb begin
    logic a;
    logic b;
    a = tie_pci_irqs_reg ? (pci_int_req[0] || pci_int_req[1]) : pci_int_req[0];
    b = tie_pci_irqs_reg ? 1'b0 : pci_int_req[1];
    slots_next = 4'h0;
    slots_next[irq_slot_step_reg] = a;
    slots_next[2'(irq_slot_step_reg + 2'h1)] = b;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      serial_irq_stream <= 4'h0;
    end else begin
      serial_irq_stream <= slots_next;
    end
  end

  // Generated switch clock: a divider of clk_sys, idle low when the pin is an input.
  // While suspended the system must feed the pin itself, so software leaves bit 27 clear.
  always_ff @(posedge clk_sys) begin
    if (srst || !switch_clock_source_reg) begin
      swclk_cnt_reg <= 4'h0;
      swclk_reg     <= 1'b0;
    end else if (swclk_cnt_reg == bsc_pkg::SWCLK_HALF_CYC - 4'h1) begin
      swclk_cnt_reg <= 4'h0;
      swclk_reg     <= !swclk_reg;
    end else begin
      swclk_cnt_reg <= swclk_cnt_reg + 4'h1;
    end
  end

  assign switch_clock_source = switch_clock_source_reg;
  assign switch_clk_o        = swclk_reg;
  assign switch_clk_oe       = switch_clock_source_reg;

  property p_reset_image;
    @(posedge clk_sys) $past(srst, 2) && !$past(srst) && !srst && !$past(cfg_req.wr)
      && cfg_req.rd && cfg_req.offset == bsc_pkg::SYSCTL_OFFSET
      |=> cfg_rdata[31:16] == bsc_pkg::SYSCTL_RESET[31:16];
  endproperty
  a_reset_image: assert property (p_reset_image) else $error("upper half not at reset image");

  // One shared copy of step and tie follows every upper-lane write.
  property p_global_write;
    @(posedge clk_sys) disable iff (srst)
    wr_hit && cfg_req.be[bsc_pkg::LANE_HI]
      |=> irq_slot_step_reg == $past(cfg_req.wdata[bsc_pkg::STEP_LSB +: 2])
      && tie_pci_irqs_reg == $past(cfg_req.wdata[bsc_pkg::TIE_BIT]);
  endproperty
  a_global_write: assert property (p_global_write) else $error("global bits not written");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (srst)
    cfg_rvalid |-> cfg_rdata[28] == 1'b0 && cfg_rdata[23] == 1'b0 && cfg_rdata[19:16] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one");

  property p_step_native;
    @(posedge clk_sys) disable iff (srst)
    irq_slot_step_reg == 2'h0 && !tie_pci_irqs_reg && $stable(irq_slot_step_reg)
      |=> serial_irq_stream == {2'h0, $past(pci_int_req)};
  endproperty
  a_step_native: assert property (p_step_native) else $error("native slots wrong");

  property p_step_wrap;
    @(posedge clk_sys) disable iff (srst)
    irq_slot_step_reg == 2'h3 && !tie_pci_irqs_reg && $stable(irq_slot_step_reg) && $stable(tie_pci_irqs_reg)
      |=> serial_irq_stream[3] == $past(pci_int_req[0]) && serial_irq_stream[0] == $past(pci_int_req[1]);
  endproperty
  a_step_wrap: assert property (p_step_wrap) else $error("step three does not wrap");

  property p_tie;
    @(posedge clk_sys) disable iff (srst)
    tie_pci_irqs_reg && $stable(tie_pci_irqs_reg) && $stable(irq_slot_step_reg)
      |=> $countones(serial_irq_stream) == ($past(pci_int_req) != 2'h0 ? 1 : 0);
  endproperty
  a_tie: assert property (p_tie) else $error("tied interrupts use two slots");

  property p_irq_route;
    @(posedge clk_sys) disable iff (srst)
    power_write_irq_enable_reg && sock_bits[0].flag
      |-> (power_write_irq_route_reg ? card_status_change_irq[0] && !irq2_req : irq2_req);
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("power write interrupt misrouted");

  property p_irq_held;
    @(posedge clk_sys) disable iff (srst)
    !power_write_irq_enable_reg |-> !irq2_req && card_status_change_irq == 2'h0;
  endproperty
  a_irq_held: assert property (p_irq_held) else $error("interrupt raised while disabled");

  property p_swclk_off;
    @(posedge clk_sys) disable iff (srst)
    !switch_clock_source_reg |-> !switch_clk_oe ##1 (switch_clock_source_reg || !switch_clk_o);
  endproperty
  a_swclk_off: assert property (p_swclk_off) else $error("switch clock driven while external");

  property p_swclk_period;
    @(posedge clk_sys) disable iff (srst)
    switch_clock_source_reg && $rose(swclk_reg) ##1 switch_clock_source_reg[*6]
      |-> ##1 !swclk_reg || !switch_clock_source_reg;
  endproperty
  a_swclk_period: assert property (p_swclk_period) else $error("switch clock half period wrong");

  c_tie_on:    cover property (@(posedge clk_sys) disable iff (srst) tie_pci_irqs_reg && pci_int_req == 2'h3);
  c_step_two:  cover property (@(posedge clk_sys) disable iff (srst) irq_slot_step_reg == 2'h2 && |serial_irq_stream);
  c_csc_route: cover property (@(posedge clk_sys) disable iff (srst) card_status_change_irq[1]);
  c_swclk:     cover property (@(posedge clk_sys) disable iff (srst) $rose(switch_clk_o));

endmodule : bsc_sysctl
